// [rsv_pkg.sv]
// shared constants and types for the reserve command handler
package rsv_pkg;
    localparam logic [7:0]  OP_RESERVE   = 8'h16;
    localparam logic [7:0]  OP_RELEASE   = 8'h17;
    localparam logic [7:0]  OP_INQUIRY   = 8'h12;
    localparam logic [7:0]  OP_REQ_SENSE = 8'h03;
    localparam logic [7:0]  ST_GOOD      = 8'h00;
    localparam logic [7:0]  ST_CHECK     = 8'h02;
    localparam logic [7:0]  ST_CONFLICT  = 8'h18;
    localparam logic [3:0]  KEY_NONE     = 4'h0;
    localparam logic [3:0]  KEY_ILLEGAL  = 4'h5;
    localparam logic [7:0]  ASC_NONE     = 8'h00;
    localparam logic [7:0]  ASC_LEN_ERR  = 8'h1a;
    localparam logic [7:0]  ASC_PARAM    = 8'h26;
    localparam logic [7:0]  ASCQ_FIELD   = 8'h00;
    localparam logic [7:0]  ASCQ_VALUE   = 8'h02;
    localparam logic [15:0] PTR_NONE     = 16'h0000;
    localparam logic [15:0] PTR_LIST_LEN = 16'h0003;
    localparam logic [15:0] DESC_BYTES   = 16'h0006;
    localparam logic [2:0]  DESC_LAST    = 3'h5;
    localparam int          ID_BITS      = 9;  // room for 512 reservation identifiers
    localparam int          N_TYPES      = 4;
    // element address ranges per element type
    localparam logic [15:0] TYPE_FIRST [N_TYPES] = '{16'h0000, 16'h0002, 16'h0032, 16'h003a};
    localparam logic [15:0] TYPE_LAST  [N_TYPES] = '{16'h0001, 16'h0031, 16'h0039, 16'h003b};

    typedef enum logic [1:0] {E_FREE = 2'h0, E_PEND = 2'h1, E_HELD = 2'h2} ent_state_type;

    typedef struct packed {
        ent_state_type       st;
        logic [2:0]          holder;
        logic [2:0]          creator;
        logic [ID_BITS-1:0]  id;
    } entry_type;

    typedef struct packed {
        logic [7:0]  status;
        logic [3:0]  key;
        logic [7:0]  asc;
        logic [7:0]  ascq;
        logic        cd;
        logic [15:0] ptr;
    } result_type;

    localparam result_type RES_GOOD = '{ST_GOOD, KEY_NONE, ASC_NONE, ASCQ_FIELD, 1'b0, PTR_NONE};
    localparam result_type RES_CONFLICT =
        '{ST_CONFLICT, KEY_NONE, ASC_NONE, ASCQ_FIELD, 1'b0, PTR_NONE};

    typedef enum logic [3:0] {
        SC_COMMIT = 4'b0001, SC_ROLLBACK = 4'b0010, SC_RELEASE = 4'b0100, SC_CLEAR = 4'b1000
    } scan_type;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001, S_DESC = 6'b000010, S_RD = 6'b000100,
        S_CHK = 6'b001000, S_SCAN = 6'b010000, S_DONE = 6'b100000
    } state_type;
endpackage

// [tab_if.sv]
// port bundle between the handler and its element table
`timescale 1ns/1ps
interface tab_if #(parameter int AW = 6);
    logic                 we;
    logic [AW-1:0]        waddr;
    logic [AW-1:0]        raddr;
    rsv_pkg::entry_type   wdata;
    rsv_pkg::entry_type   rdata;
    modport ctrl (output we, waddr, raddr, wdata, input rdata);
    modport mem (input we, waddr, raddr, wdata, output rdata);
endinterface

// [rsv_table.sv]
// element reservation table, one entry per element address
`timescale 1ns/1ps
module rsv_table #(
    parameter int N_ELEM = 64,
    parameter int AW     = 6
) (
    input wire logic clk,
    tab_if.mem       t
);
    import rsv_pkg::*;
    entry_type mem [N_ELEM];

    // no reset here: the handler scrubs every entry after reset
    always_ff @(posedge clk) begin
        if (t.we) begin
            mem[t.waddr] <= t.wdata;
        end
        t.rdata <= mem[t.raddr];  // read data one cycle after the address
    end
endmodule

// [reserve_command_handler.sv]
// reserve command decoding, unit and element reservation bookkeeping
`timescale 1ns/1ps
module reserve_command_handler
    import rsv_pkg::*;
#(
    parameter int N_ELEM = 64
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        cmd_start,
    output logic                             cmd_ready,
    input  wire logic [2:0]                  cmd_initiator,
    input  wire logic [7:0]                  cmd_opcode,
    input  wire logic                        cmd_third_party_flag,
    input  wire logic [2:0]                  cmd_third_party_id,
    input  wire logic                        cmd_element_select,
    input  wire logic [rsv_pkg::ID_BITS-1:0] cmd_res_id,
    input  wire logic [15:0]                 cmd_list_len,
    input  wire logic                        list_valid,
    output logic                             list_ready,
    input  wire logic [7:0]                  list_byte,
    input  wire logic                        rel_start,
    input  wire logic [2:0]                  rel_initiator,
    input  wire logic                        rel_unit,
    input  wire logic [rsv_pkg::ID_BITS-1:0] rel_id,
    input  wire logic                        bus_device_reset,
    output logic                             done,
    output logic [7:0]                       status,
    output logic [3:0]                       sense_key,
    output logic [7:0]                       asc,
    output logic [7:0]                       ascq,
    output logic                             cd_bit,
    output logic [15:0]                      field_ptr,
    output logic                             unit_reserved,
    output logic [2:0]                       unit_owner
);
    import rsv_pkg::*;
    localparam int AW = $clog2(N_ELEM);
    localparam logic [AW:0] IDX_END = (AW+1)'(N_ELEM);

    typedef struct packed {
        state_type           state;
        scan_type            op;
        logic                unit_held;
        logic [2:0]          unit_holder;
        logic [2:0]          unit_creator;
        logic [2:0]          ini;
        logic [2:0]          holder;
        logic [ID_BITS-1:0]  res_id;
        logic [15:0]         remain;
        logic [15:0]         list_len;
        logic [2:0]          bcnt;
        logic                rsv_bad;
        logic [15:0]         cnt;
        logic [15:0]         addr;
        logic [15:0]         cur;
        logic [15:0]         last;
        logic [AW:0]         idx;
        logic                refuse;
        result_type          res;
    } st_type;

    st_type      st;
    st_type      next_st;
    tab_if #(.AW(AW)) tab ();
    logic [2:0]  req_holder;
    logic        foreign_unit;
    logic        exempt;
    logic [15:0] desc_addr;
    logic [15:0] t_last;
    logic        t_hit;
    logic [16:0] span_last;
    logic        desc_ok;
    logic        refuse_now;
    entry_type   e;

    rsv_table #(.N_ELEM(N_ELEM), .AW(AW)) u_rsv_table (
        .clk (clk),
        .t   (tab.mem)
    );

    // handshake and result outputs
    assign cmd_ready     = (st.state == S_IDLE);
    assign list_ready    = (st.state == S_DESC);
    assign done          = (st.state == S_DONE);
    assign status        = st.res.status;
    assign sense_key     = st.res.key;
    assign asc           = st.res.asc;
    assign ascq          = st.res.ascq;
    assign cd_bit        = st.res.cd;
    assign field_ptr     = st.res.ptr;
    assign unit_reserved = st.unit_held;
    assign unit_owner    = st.unit_holder;

    // access is granted to the third party, not to the requester
    assign req_holder   = cmd_third_party_flag ? cmd_third_party_id : cmd_initiator;
    assign foreign_unit = st.unit_held && (st.unit_holder != cmd_initiator);
    assign exempt       = (cmd_opcode == OP_INQUIRY) || (cmd_opcode == OP_REQ_SENSE) ||
                          (cmd_opcode == OP_RELEASE);
    assign desc_addr    = {st.addr[15:8], list_byte};
    assign span_last    = {1'b0, desc_addr} + {1'b0, st.cnt} - 17'h00001;
    assign e            = tab.rdata;

    // element type lookup; a descriptor may not run past its own type
    always_comb begin
        t_hit  = 1'b0;
        t_last = 16'h0000;
        for (int i = 0; i < N_TYPES; i++) begin
            if (desc_addr >= TYPE_FIRST[i] && desc_addr <= TYPE_LAST[i]) begin
                t_hit  = 1'b1;
                t_last = TYPE_LAST[i];
            end
        end
        desc_ok = t_hit && ((st.cnt == 16'h0000) || (span_last <= {1'b0, t_last}));
    end

    // next state of the whole handler
    always_comb begin
        next_st     = st;
        refuse_now  = 1'b0;
        tab.we      = 1'b0;
        tab.waddr   = st.cur[AW-1:0];
        tab.raddr   = st.cur[AW-1:0];
        tab.wdata   = '{E_FREE, 3'h0, 3'h0, {ID_BITS{1'b0}}};
        unique case (st.state)
            S_IDLE: begin
                if (cmd_start) begin
                    next_st.ini      = cmd_initiator;
                    next_st.holder   = req_holder;
                    next_st.res_id   = cmd_res_id;
                    next_st.remain   = cmd_list_len;
                    next_st.list_len = cmd_list_len;
                    next_st.bcnt     = 3'h0;
                    next_st.rsv_bad  = 1'b0;
                    next_st.res      = RES_GOOD;
                    next_st.state    = S_DONE;
                    if (cmd_opcode != OP_RESERVE) begin
                        if (foreign_unit && !exempt) begin
                            next_st.res = RES_CONFLICT;
                        end
                    end else if (foreign_unit) begin
                        next_st.res = RES_CONFLICT;
                    end else if (!cmd_element_select) begin
                        // list length is ignored for a unit reservation
                        next_st.unit_held    = 1'b1;
                        next_st.unit_holder  = req_holder;
                        next_st.unit_creator = cmd_initiator;
                    end else if (st.unit_held) begin
                        next_st.res = RES_CONFLICT;
                    end else if ((cmd_list_len % DESC_BYTES) != 16'h0000) begin
                        next_st.res = '{ST_CHECK, KEY_ILLEGAL, ASC_LEN_ERR, ASCQ_FIELD,
                                        1'b1, PTR_LIST_LEN};
                    end else if (cmd_list_len != 16'h0000) begin
                        next_st.state = S_DESC;
                    end
                end else if (rel_start) begin
                    next_st.ini    = rel_initiator;
                    next_st.res    = RES_GOOD;
                    next_st.state  = S_DONE;
                    next_st.refuse = 1'b0;
                    if (rel_unit && st.unit_held) begin
                        if (rel_initiator == st.unit_creator) begin
                            // owner reads zero whenever nothing is reserved
                            next_st.unit_held   = 1'b0;
                            next_st.unit_holder = 3'h0;
                        end else if (rel_initiator == st.unit_holder) begin
                            next_st.res = RES_CONFLICT;
                        end
                    end else if (!rel_unit) begin
                        next_st.res_id = rel_id;
                        next_st.op     = SC_RELEASE;
                        next_st.idx    = '0;
                        next_st.state  = S_SCAN;
                    end
                end
            end
            S_DESC: begin
                if (list_valid) begin
                    next_st.remain = st.remain - 16'h0001;
                    next_st.bcnt   = (st.bcnt == DESC_LAST) ? 3'h0 : st.bcnt + 3'h1;
                    unique case (st.bcnt)
                        3'h0, 3'h1: next_st.rsv_bad = st.rsv_bad | (list_byte != 8'h00);
                        3'h2: next_st.cnt[15:8] = list_byte;
                        3'h3: next_st.cnt[7:0] = list_byte;
                        3'h4: next_st.addr[15:8] = list_byte;
                        default: begin
                            next_st.rsv_bad = 1'b0;
                            next_st.op      = SC_ROLLBACK;
                            next_st.idx     = '0;
                            next_st.state   = S_SCAN;
                            if (st.rsv_bad) begin
                                next_st.res = '{ST_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_FIELD, 1'b0,
                                    st.list_len - st.remain - {13'h0000, DESC_LAST}};
                            end else if (!desc_ok) begin
                                next_st.res = '{ST_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_VALUE, 1'b0,
                                    st.list_len - st.remain - 16'h0001};
                            end else begin
                                next_st.cur   = desc_addr;
                                next_st.last  = (st.cnt == 16'h0000) ? t_last
                                                                     : span_last[15:0];
                                next_st.state = S_RD;
                            end
                        end
                    endcase
                end
            end
            S_RD: next_st.state = S_CHK;
            S_CHK: begin
                if (e.st == E_PEND) begin
                    // already taken earlier in this same list: overlapping ranges
                    next_st.res   = '{ST_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_VALUE, 1'b0, PTR_NONE};
                    next_st.op    = SC_ROLLBACK;
                    next_st.idx   = '0;
                    next_st.state = S_SCAN;
                end else if (e.st == E_HELD && e.holder != st.holder) begin
                    next_st.res   = RES_CONFLICT;
                    next_st.op    = SC_ROLLBACK;
                    next_st.idx   = '0;
                    next_st.state = S_SCAN;
                end else begin
                    // an element the requester already holds is left untouched,
                    // so a later rollback cannot drop it
                    if (e.st == E_FREE) begin
                        tab.we    = 1'b1;
                        tab.wdata = '{E_PEND, st.holder, st.ini, st.res_id};
                    end
                    if (st.cur != st.last) begin
                        next_st.cur   = st.cur + 16'h0001;
                        next_st.state = S_RD;
                    end else if (st.remain != 16'h0000) begin
                        next_st.state = S_DESC;
                    end else begin
                        next_st.op    = SC_COMMIT;
                        next_st.idx   = '0;
                        next_st.state = S_SCAN;
                    end
                end
            end
            S_SCAN: begin
                // pipelined sweep: address idx is read while idx-1 is acted on
                tab.raddr = st.idx[AW-1:0];
                tab.waddr = st.idx[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
                tab.wdata = e;
                if (st.idx != '0) begin
                    unique case (st.op)
                        SC_COMMIT: begin
                            tab.we       = (e.st == E_PEND);
                            tab.wdata.st = E_HELD;
                        end
                        SC_ROLLBACK: begin
                            tab.we       = (e.st == E_PEND);
                            tab.wdata.st = E_FREE;
                        end
                        SC_RELEASE: begin
                            tab.wdata.st = E_FREE;
                            if (e.st == E_HELD && e.id == st.res_id) begin
                                tab.we     = (e.creator == st.ini);
                                refuse_now = (e.creator != st.ini) && (e.holder == st.ini);
                            end
                        end
                        SC_CLEAR: begin
                            tab.we       = 1'b1;
                            tab.wdata.st = E_FREE;
                        end
                    endcase
                end
                next_st.refuse = st.refuse | refuse_now;
                if (st.idx == IDX_END) begin
                    next_st.state = (st.op == SC_CLEAR) ? S_IDLE : S_DONE;
                    if (st.op == SC_RELEASE && (st.refuse || refuse_now)) begin
                        next_st.res = RES_CONFLICT;
                    end
                end else begin
                    next_st.idx = st.idx + {{AW{1'b0}}, 1'b1};
                end
            end
            S_DONE: next_st.state = S_IDLE;
        endcase
        // a bus device reset drops every reservation and aborts the command
        if (bus_device_reset) begin
            next_st.unit_held   = 1'b0;
            next_st.unit_holder = 3'h0;
            next_st.op        = SC_CLEAR;
            next_st.idx       = '0;
            next_st.state     = S_SCAN;
        end
    end

    // state register; a hard reset starts with a table scrub
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.state <= S_SCAN;
            st.op    <= SC_CLEAR;
        end else begin
            st <= next_st;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic take_rsv;
    logic desc_end;
    assign take     = cmd_start && cmd_ready && !bus_device_reset;
    assign take_rsv = take && (cmd_opcode == OP_RESERVE);
    assign desc_end = list_ready && list_valid && (st.bcnt == DESC_LAST) && !bus_device_reset;

    a_len_error_sense: assert property (
        take_rsv && cmd_element_select && !unit_reserved && (cmd_list_len % DESC_BYTES) != 0
        |=> done && sense_key == KEY_ILLEGAL && asc == ASC_LEN_ERR && ascq == ASCQ_FIELD
            && cd_bit && field_ptr == PTR_LIST_LEN)
        else $error("bad list length not reported");
    a_busy_conflict: assert property (
        take && !exempt && cmd_opcode != OP_RESERVE && unit_reserved && unit_owner != cmd_initiator
        |=> done && status == ST_CONFLICT)
        else $error("reserved unit did not refuse other initiator");
    a_unit_third: assert property (
        take_rsv && !cmd_element_select && cmd_third_party_flag && !unit_reserved
        |=> unit_reserved && unit_owner == $past(cmd_third_party_id) && done)
        else $error("third party unit reservation not recorded");
    a_empty_list: assert property (
        take_rsv && cmd_element_select && !unit_reserved && cmd_list_len == 16'h0000
        |=> done && status == ST_GOOD)
        else $error("empty element list did not complete good");
    a_unit_blocks: assert property (
        take_rsv && cmd_element_select && unit_reserved |=> done && status == ST_CONFLICT)
        else $error("element reserved inside reserved unit");
    a_third_release: assert property (
        rel_start && cmd_ready && !cmd_start && !bus_device_reset && rel_unit && unit_reserved
            && rel_initiator == unit_owner && rel_initiator != st.unit_creator
        |=> done && status == ST_CONFLICT && unit_reserved)
        else $error("third party released its own reservation");
    a_reset_clears: assert property (
        bus_device_reset |=> !unit_reserved && !cmd_ready && st.op == SC_CLEAR)
        else $error("bus device reset left reservations");
    a_reserved_field: assert property (
        desc_end && st.rsv_bad |=> st.state == S_SCAN && st.op == SC_ROLLBACK
            && st.res.asc == ASC_PARAM && st.res.ascq == ASCQ_FIELD && !st.res.cd)
        else $error("nonzero reserved field accepted");
    a_bad_address: assert property (
        desc_end && !st.rsv_bad && !desc_ok |=> st.op == SC_ROLLBACK
            && st.res.asc == ASC_PARAM && st.res.ascq == ASCQ_VALUE)
        else $error("invalid element address accepted");
    a_open_range: assert property (
        desc_end && !st.rsv_bad && desc_ok && st.cnt == 16'h0000
        |=> st.state == S_RD && st.last == $past(t_last))
        else $error("zero count did not run to end of type");
    a_elem_conflict: assert property (
        st.state == S_CHK && e.st == E_HELD && e.holder != st.holder && !bus_device_reset
        |=> st.op == SC_ROLLBACK && st.res.status == ST_CONFLICT)
        else $error("held element reserved by another initiator");
    a_good_end: assert property (
        st.state == S_SCAN && st.op == SC_COMMIT && st.idx == IDX_END && !bus_device_reset
        |=> done && status == ST_GOOD ##1 cmd_ready)
        else $error("committed reservation did not end good");
    a_pending_tag: assert property (
        tab.we && tab.wdata.st == E_PEND |-> st.state == S_CHK && tab.wdata.id == st.res_id
            && tab.wdata.holder == st.holder && tab.waddr == st.cur[AW-1:0])
        else $error("element tagged with wrong identifier");
endmodule

// [host_list_source.sv]
// host side model streaming one element list descriptor
`timescale 1ns/1ps
module host_list_source (
    input  wire logic        clk,
    input  wire logic        load,
    input  wire logic [47:0] desc,
    input  wire logic        list_ready,
    output logic             list_valid,
    output logic [7:0]       list_byte
);
    logic [47:0] sr = '0;
    logic [2:0]  left = '0;
    // whole six-byte descriptors, msb first; rotating keeps the last byte at the bottom
    always_ff @(posedge clk) begin
        if (load) begin
            sr <= desc;
            left <= 3'h6;
        end else if (list_valid && list_ready) begin
            sr <= {sr[39:0], sr[47:40]};
            left <= left - 3'h1;
        end
    end
    assign list_valid = (left != 3'h0);
    // released line shows the inverse of the last byte, never a stale copy
    assign list_byte = list_valid ? sr[47:40] : ~sr[7:0];
endmodule

// [reserve_command_handler_test.sv]
// self-checking bench for the reserve command handler
`timescale 1ns/1ps
module reserve_command_handler_test;
    import rsv_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, cmd_start = 1'b0, rel_start = 1'b0, load = 1'b0;
    logic        cmd_third_party_flag = 1'b0, cmd_element_select = 1'b0, rel_unit = 1'b0;
    logic        bus_device_reset = 1'b0, cmd_ready, list_valid, list_ready, done, cd_bit;
    logic        unit_reserved;
    logic [2:0]  cmd_initiator = 3'h0, cmd_third_party_id = 3'h0, rel_initiator = 3'h0;
    logic [2:0]  unit_owner;
    logic [7:0]  cmd_opcode = 8'h00, list_byte, status, asc, ascq;
    logic [3:0]  sense_key;
    logic [8:0]  cmd_res_id = 9'h000, rel_id = 9'h000;
    logic [15:0] cmd_list_len = 16'h0000, field_ptr;
    logic [47:0] desc = 48'h0;
    logic [44:0] res, own;
    int          n_mismatch = 0, check_count = 0, cycles = 0;
    assign res = {status, sense_key, asc, ascq, cd_bit, field_ptr};
    assign own = 45'({unit_reserved, unit_owner});
    always #12.5 clk = ~clk;
    reserve_command_handler u_reserve_command_handler (.clk, .rst_n, .cmd_start, .cmd_ready,
        .cmd_initiator, .cmd_opcode, .cmd_third_party_flag, .cmd_third_party_id,
        .cmd_element_select, .cmd_res_id, .cmd_list_len, .list_valid, .list_ready, .list_byte,
        .rel_start, .rel_initiator, .rel_unit, .rel_id, .bus_device_reset, .done, .status,
        .sense_key, .asc, .ascq, .cd_bit, .field_ptr, .unit_reserved, .unit_owner);
    host_list_source u_host_list_source (.clk, .load, .desc, .list_ready, .list_valid,
        .list_byte);

    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // look a moment after the edge, once combinational handshakes have settled
    task automatic wait_for(ref logic s);
        #1;
        while (s !== 1'b1) begin
            @(posedge clk);
            #1;
        end
    endtask
    // one request; releases are judged by the unit state, commands by the result bytes
    task automatic req(input logic q, input logic [2:0] i, input logic [7:0] o,
                       input logic [3:0] t, input logic s, input logic [15:0] l,
                       input logic [47:0] d, input logic [8:0] r, input logic [44:0] e);
        wait_for(cmd_ready);
        @(posedge clk);
        {cmd_initiator, rel_initiator, cmd_opcode} <= {i, i, o};
        {cmd_third_party_flag, cmd_third_party_id, cmd_element_select, rel_unit} <= {t, s, s};
        {cmd_list_len, desc, cmd_res_id, rel_id} <= {l, d, r, r};
        {cmd_start, rel_start, load} <= {!q, q, !q};
        @(posedge clk);
        {cmd_start, rel_start, load} <= 3'h0;
        wait_for(done);
        check_count++;
        if ((q ? own : res) !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, q ? own : res, e);
        end
    endtask
    // hang guard, well above the several hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        req('0, 3'h1, OP_RESERVE, '0, '0, '0, '0, '0, RES_GOOD);
        req('0, 3'h2, 8'h00, '0, '0, '0, '0, '0, RES_CONFLICT);
        req('0, 3'h2, OP_INQUIRY, '0, '0, '0, '0, '0, RES_GOOD);
        req('0, 3'h2, OP_RESERVE, '0, '0, '0, '0, '0, RES_CONFLICT);
        req('0, 3'h1, OP_RESERVE, '0, '1, 16'h6, 48'h1_0002, '0, RES_CONFLICT);
        req('1, 3'h1, '0, '0, '1, '0, '0, '0, 45'h0);
        req('0, 3'h1, OP_RESERVE, 4'hb, '0, '0, '0, '0, RES_GOOD);
        req('0, 3'h3, 8'h00, '0, '0, '0, '0, '0, RES_GOOD);
        req('0, 3'h1, 8'h00, '0, '0, '0, '0, '0, RES_CONFLICT);
        req('1, 3'h3, '0, '0, '1, '0, '0, '0, 45'hb);
        @(posedge clk);
        bus_device_reset <= 1'b1;
        @(posedge clk);
        bus_device_reset <= 1'b0;
        req('1, 3'h1, '0, '0, '1, '0, '0, '0, 45'h0);
        req('0, 3'h1, OP_RESERVE, '0, '1, 16'h5, '0, '0,
            {ST_CHECK, KEY_ILLEGAL, ASC_LEN_ERR, ASCQ_FIELD, 1'b1, PTR_LIST_LEN});
        req('0, 3'h1, OP_RESERVE, '0, '1, '0, '0, '0, RES_GOOD);
        req('0, 3'h1, OP_RESERVE, '0, '1, 16'h6, 48'h0001_0001_0002, '0,
            {ST_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_FIELD, 1'b0, PTR_NONE});
        req('0, 3'h1, OP_RESERVE, '0, '1, 16'h6, 48'h1_0040, '0,
            {ST_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_VALUE, 1'b0, 16'h0004});
        req('0, 3'h1, OP_RESERVE, '0, '1, 16'h6, 48'h32, 9'h1ff, RES_GOOD);
        req('0, 3'h2, OP_RESERVE, '0, '1, 16'h6, 48'h1_0039, 9'h7, RES_CONFLICT);
        req('1, 3'h1, '0, '0, '0, '0, '0, 9'h1ff, 45'h0);
        req('0, 3'h2, OP_RESERVE, '0, '1, 16'h6, 48'h1_0039, 9'h7, RES_GOOD);
        give_verdict();
    end
endmodule
